// ==== verilog/rsc_defs.vh ====
// constants for the reset source controller
`ifndef RSC_DEFS_VH
`define RSC_DEFS_VH

// register byte offsets on the AXI4-Lite bus
`define RSC_OFS_THRESH 4'h0
`define RSC_OFS_CAUSE 4'h4
`define RSC_OFS_STATUS 4'h8
`define RSC_ADDR_W 4
// parks a write whose high address bits are set on an unmapped offset
`define RSC_OFS_NONE 4'hC

// AXI response codes
`define RSC_RESP_OKAY 2'h0
`define RSC_RESP_SLVERR 2'h2

// threshold select codes, all select the same trip level
`define RSC_THRESH_RESET 8'h55
`define RSC_CODE_A 8'h55
`define RSC_CODE_B 8'h33
`define RSC_CODE_C 8'h99
`define RSC_CODE_D 8'hAA

// cause register bit positions
`define RSC_BIT_UV 2
`define RSC_BIT_THR 1
`define RSC_BIT_WDR 0

// status register bit positions
`define RSC_BIT_TO 1
`define RSC_BIT_PD 0

// times and derived counts at the core clock rate
`define RSC_CLK_MHZ 100
`define RSC_UV_QUALIFY_NS 1000
`define RSC_UV_QUALIFY_CYC (((`RSC_UV_QUALIFY_NS * `RSC_CLK_MHZ) + 999) / 1000)
`define RSC_CNT_W 16
`define RSC_DEBOUNCE_EDGES 2'h3
`define RSC_FULL_RST_CYC 5'h04
`define RSC_START_FAST_CYC 5'h10
`define RSC_START_SLOW_CYC 5'h02
`define RSC_STATE_CNT_W 5

`endif

// ==== verilog/rsc_reset_source_controller.v ====
// reset source controller: merges reset causes and keeps cause flags
//
// Function
// [R1] power-on fetch starts at address zero
// [R2] power-on loads port data/direction all ones
// [R3] qualified low supply resets, sets cause flag
// [R4] short low-supply glitch is ignored
// [R5] only four threshold codes are valid
// [R6] invalid code resets after 2-3 slow edges
// [R7] invalid-code reset sets threshold cause flag
// [R8] threshold register powers up as 0x55
// [R9] low-voltage function off in power-down
// [R10] software may write any threshold code
// [R11] undervoltage flag bit 2, software clears
// [R12] normal watchdog timeout: full reset, sets timeout
// [R13] sleep watchdog timeout clears only pc, sp
// [R14] wake start-up 16 fast or 2 slow
// [R15] por clears flags; sleep timeout sets both
// [R16] one merged synchronous reset, flags same cycle
`timescale 1ns/1ns
`include "rsc_defs.vh"

module rsc_reset_source_controller (
    // clock, reset, enable
    input wire aclk,
    input wire aresetn,
    input wire ce,
    // AXI4-Lite write address
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // analog and oscillator pins, asynchronous
    input wire undervoltage_detect,
    input wire slow_internal_osc,
    // core status, same clock
    input wire powerdown_mode,
    input wire sleep_idle_mode,
    input wire sys_clk_is_slow,
    input wire watchdog_timeout,
    input wire watchdog_reg_corrupt,
    // reset outputs to the core
    output reg sys_reset,
    output reg core_restart,
    output reg startup_hold,
    output reg timeout_flag,
    output reg powerdown_flag
);

    localparam S_IDLE = 2'b00;
    localparam S_RESET = 2'b01;
    localparam S_START = 2'b10;

    // synchronisers
    reg uv_s1_reg;
    reg uv_s2_reg;
    reg osc_s1_reg;
    reg osc_s2_reg;
    reg osc_s3_reg;

    // registers
    reg [7:0] threshold_code_reg;
    reg undervoltage_cause_flag_reg;
    reg threshold_reg_reset_flag_reg;
    reg watchdog_reg_reset_flag_reg;

    // sequencing
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [`RSC_STATE_CNT_W-1:0] cnt_reg;
    reg [`RSC_STATE_CNT_W-1:0] cnt_next;
    reg [`RSC_CNT_W-1:0] uv_cnt_reg;
    reg [1:0] deb_cnt_reg;

    // bus capture
    reg aw_have_reg;
    reg w_have_reg;
    reg [`RSC_ADDR_W-1:0] awaddr_reg;
    reg [7:0] wdata_reg;
    reg wstrb0_reg;
    reg [7:0] rd_byte;

    wire osc_edge = osc_s2_reg & ~osc_s3_reg;
    wire code_valid = (threshold_code_reg == `RSC_CODE_A) || // R5
        (threshold_code_reg == `RSC_CODE_B) ||
        (threshold_code_reg == `RSC_CODE_C) ||
        (threshold_code_reg == `RSC_CODE_D);
    wire uv_enable = ~powerdown_mode; // R9
    wire in_reset = (state_reg == S_RESET);

    // a glitch shorter than the qualify time never reaches the count
    wire uv_evt = uv_enable & uv_s2_reg & ~in_reset & // R4
        (uv_cnt_reg >= `RSC_UV_QUALIFY_CYC); // R3
    // the debounce trips on the third slow edge: 2 to 3 slow periods
    wire thr_evt = uv_enable & ~code_valid & ~in_reset & osc_edge & // R6
        (deb_cnt_reg == `RSC_DEBOUNCE_EDGES - 2'h1);
    wire wdt_norm_evt = watchdog_timeout & ~sleep_idle_mode & ~in_reset; // R12
    wire wdt_wake_evt = watchdog_timeout & sleep_idle_mode & ~in_reset; // R13
    wire wdr_evt = watchdog_reg_corrupt & ~in_reset;
    wire full_evt = uv_evt | thr_evt | wdt_norm_evt | wdr_evt; // R16

    // bus write decode
    wire wr_fire = aw_have_reg & w_have_reg & ~s_axi_bvalid;
    wire wr_lane = wr_fire & wstrb0_reg;
    wire wr_thresh = wr_lane && (awaddr_reg == `RSC_OFS_THRESH);
    wire wr_cause = wr_lane && (awaddr_reg == `RSC_OFS_CAUSE);
    wire wr_map = (awaddr_reg == `RSC_OFS_THRESH) ||
        (awaddr_reg == `RSC_OFS_CAUSE) || (awaddr_reg == `RSC_OFS_STATUS);
    wire [`RSC_ADDR_W-1:0] raddr = s_axi_araddr[`RSC_ADDR_W-1:0];
    wire rd_map = (s_axi_araddr[31:`RSC_ADDR_W] == 28'h0000000) &&
        ((raddr == `RSC_OFS_THRESH) || (raddr == `RSC_OFS_CAUSE) ||
        (raddr == `RSC_OFS_STATUS));

    // next state of the reset sequencer
    always @* begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            S_IDLE, S_START: begin
                if (full_evt) begin
                    state_next = S_RESET;
                    cnt_next = `RSC_FULL_RST_CYC;
                end else if (wdt_wake_evt) begin
                    state_next = S_START; // R14
                    cnt_next = sys_clk_is_slow ? `RSC_START_SLOW_CYC :
                        `RSC_START_FAST_CYC;
                end else if (state_reg == S_START) begin
                    cnt_next = cnt_reg - 5'h01;
                    if (cnt_reg == 5'h01) begin
                        state_next = S_IDLE;
                    end
                end
            end
            S_RESET: begin
                cnt_next = cnt_reg - 5'h01;
                if (cnt_reg == 5'h01) begin
                    state_next = S_IDLE;
                end
            end
            default: begin
                state_next = S_IDLE;
                cnt_next = 5'h00;
            end
        endcase
    end

    // synchronisers are held clear in reset and start sampling the pins at release
    always @(posedge aclk) begin
        if (!aresetn) begin
            uv_s1_reg <= 1'b0;
            uv_s2_reg <= 1'b0;
            osc_s1_reg <= 1'b0;
            osc_s2_reg <= 1'b0;
            osc_s3_reg <= 1'b0;
        end else if (ce) begin
            uv_s1_reg <= undervoltage_detect;
            uv_s2_reg <= uv_s1_reg;
            osc_s1_reg <= slow_internal_osc;
            osc_s2_reg <= osc_s1_reg;
            osc_s3_reg <= osc_s2_reg;
        end
    end

    // sequencer, filters and outputs
    always @(posedge aclk) begin
        if (!aresetn) begin
            // power-on: core held, pc to zero, ports to all ones
            state_reg <= S_IDLE;
            cnt_reg <= 5'h00;
            uv_cnt_reg <= 16'h0000;
            deb_cnt_reg <= 2'h0;
            sys_reset <= 1'b1; // R1 R2
            core_restart <= 1'b1; // R1
            startup_hold <= 1'b0;
            timeout_flag <= 1'b0; // R15
            powerdown_flag <= 1'b0; // R15
        end else if (ce) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            // ports reload all ones and fetch restarts at zero while held
            sys_reset <= (state_next == S_RESET); // R2 R16
            core_restart <= (state_next == S_RESET) | wdt_wake_evt; // R1 R13
            startup_hold <= (state_next == S_START); // R14
            if (uv_enable && uv_s2_reg && !in_reset) begin
                if (uv_cnt_reg != 16'hFFFF) begin
                    uv_cnt_reg <= uv_cnt_reg + 16'h0001; // R3
                end
            end else begin
                uv_cnt_reg <= 16'h0000; // R4 R9
            end
            if (code_valid || !uv_enable || in_reset) begin
                deb_cnt_reg <= 2'h0;
            end else if (osc_edge) begin
                deb_cnt_reg <= deb_cnt_reg + 2'h1; // R6
            end
            // an undervoltage reset leaves both flags unchanged
            if (wdt_norm_evt) begin
                timeout_flag <= 1'b1; // R12
            end
            if (wdt_wake_evt) begin
                timeout_flag <= 1'b1; // R13 R15
                powerdown_flag <= 1'b1; // R15
            end
        end
    end

    // software registers; hardware sets win over software clears
    always @(posedge aclk) begin
        if (!aresetn) begin
            threshold_code_reg <= `RSC_THRESH_RESET; // R8
            undervoltage_cause_flag_reg <= 1'b0;
            threshold_reg_reset_flag_reg <= 1'b0;
            watchdog_reg_reset_flag_reg <= 1'b0;
        end else if (ce) begin
            if (full_evt) begin
                // reload a valid code or the block would reset forever
                threshold_code_reg <= `RSC_THRESH_RESET;
            end else if (wr_thresh) begin
                threshold_code_reg <= wdata_reg; // R10
            end
            if (uv_evt) begin
                undervoltage_cause_flag_reg <= 1'b1; // R3 R16
            end else if (wr_cause && !wdata_reg[`RSC_BIT_UV]) begin
                undervoltage_cause_flag_reg <= 1'b0; // R11
            end
            if (thr_evt) begin
                threshold_reg_reset_flag_reg <= 1'b1; // R7 R16
            end else if (wr_cause && !wdata_reg[`RSC_BIT_THR]) begin
                threshold_reg_reset_flag_reg <= 1'b0;
            end
            if (wdr_evt) begin
                watchdog_reg_reset_flag_reg <= 1'b1; // R16
            end else if (wr_cause && !wdata_reg[`RSC_BIT_WDR]) begin
                watchdog_reg_reset_flag_reg <= 1'b0;
            end
        end
    end

    // AXI4-Lite write channel: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            awaddr_reg <= 4'h0;
            wdata_reg <= 8'h00;
            wstrb0_reg <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RSC_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr[`RSC_ADDR_W-1:0];
                s_axi_awready <= 1'b0;
                if (s_axi_awaddr[31:`RSC_ADDR_W] != 28'h0000000) begin
                    awaddr_reg <= `RSC_OFS_NONE;
                end
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                wdata_reg <= s_axi_wdata[7:0];
                wstrb0_reg <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_map ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
            end
            // bits 31:8 of the write data are ignored, every register is one byte
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // read data mux; unused bits and unmapped offsets read as zero
    always @* begin
        rd_byte = 8'h00;
        case (raddr)
            `RSC_OFS_THRESH: begin
                rd_byte = threshold_code_reg;
            end
            `RSC_OFS_CAUSE: begin
                rd_byte[`RSC_BIT_UV] = undervoltage_cause_flag_reg; // R11
                rd_byte[`RSC_BIT_THR] = threshold_reg_reset_flag_reg;
                rd_byte[`RSC_BIT_WDR] = watchdog_reg_reset_flag_reg;
            end
            `RSC_OFS_STATUS: begin
                rd_byte[`RSC_BIT_TO] = timeout_flag;
                rd_byte[`RSC_BIT_PD] = powerdown_flag;
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
        // high address bits set: the read is refused, so nothing may leak out
        if (!rd_map) begin
            rd_byte = 8'h00;
        end
    end

    // AXI4-Lite read channel: data one edge after the address
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RSC_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= rd_map ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
                s_axi_rdata <= {24'h000000, rd_byte};
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

// ==== tb/rsc_asserts.sv ====
// port-level assertion checker for the reset source controller
`timescale 1ns/1ns
module rsc_asserts (
    // clock and reset
    input wire aclk, aresetn,
    // register bus
    input wire s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
    input wire s_axi_rvalid, s_axi_rready,
    input wire [1:0] s_axi_bresp, s_axi_rresp,
    input wire [31:0] s_axi_araddr, s_axi_rdata,
    // core side
    input wire sleep_idle_mode, sys_clk_is_slow, watchdog_timeout,
    input wire sys_reset, core_restart, startup_hold, timeout_flag, powerdown_flag
);
    reg [4:0] hold_cnt_reg;
    default clocking dck @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // run length of the wake hold; 5 bits hold the fast length of 16
    always @(posedge aclk) begin
        if (!aresetn || !startup_hold) begin
            hold_cnt_reg <= 5'h00;
        end else begin
            hold_cnt_reg <= hold_cnt_reg + 5'h01;
        end
    end
    a_wdt_full_reset: assert property (
        watchdog_timeout && !sleep_idle_mode && !sys_reset
        |=> sys_reset && timeout_flag && powerdown_flag == $past(powerdown_flag))
        else $error("normal timeout did not give full reset with timeout flag");
    a_sleep_restart: assert property (
        watchdog_timeout && sleep_idle_mode && !sys_reset && !startup_hold
        |=> core_restart && !sys_reset && startup_hold && timeout_flag && powerdown_flag
        ##1 !core_restart)
        else $error("sleep timeout restart wrong");
    a_flags_kept: assert property (
        $rose(sys_reset) && !$past(watchdog_timeout)
        |-> $stable(timeout_flag) && $stable(powerdown_flag))
        else $error("non-watchdog full reset changed the status flags");
    a_full_len: assert property ($rose(sys_reset) |-> sys_reset[*4] ##1 !sys_reset)
        else $error("full reset length wrong");
    a_core_follow: assert property (sys_reset |-> core_restart)
        else $error("core restart missing during full reset");
    a_wake_len: assert property (
        $fell(startup_hold) && !sys_reset
        |-> hold_cnt_reg == (sys_clk_is_slow ? 5'h02 : 5'h10))
        else $error("wake start-up delay length wrong");
    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_unmapped_rd: assert property (
        s_axi_arvalid && s_axi_arready
        && (s_axi_araddr[31:4] != 28'h0 || s_axi_araddr[3:0] == 4'hC)
        |=> s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule
bind rsc_reset_source_controller rsc_asserts chk_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_bresp(s_axi_bresp), .s_axi_rresp(s_axi_rresp),
    .s_axi_araddr(s_axi_araddr), .s_axi_rdata(s_axi_rdata),
    .sleep_idle_mode(sleep_idle_mode), .sys_clk_is_slow(sys_clk_is_slow),
    .watchdog_timeout(watchdog_timeout), .sys_reset(sys_reset),
    .core_restart(core_restart), .startup_hold(startup_hold),
    .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag)
);

// ==== tb/rsc_reset_source_controller_tb_top.sv ====
// self-checking bench for the reset source controller
`timescale 1ns/1ns
`include "rsc_defs.vh"
module rsc_reset_source_controller_tb_top;
    logic aclk = 0, aresetn = 0, ce = 1;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF, osc_cnt = 4'h0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic undervoltage_detect = 0, slow_internal_osc = 0, powerdown_mode = 0;
    logic sleep_idle_mode = 0, sys_clk_is_slow = 0;
    logic watchdog_timeout = 0, watchdog_reg_corrupt = 0;
    logic sys_reset, core_restart, startup_hold, timeout_flag, powerdown_flag;
    logic [7:0] codes [4] = '{8'h55, 8'h33, 8'h99, 8'hAA};
    logic [7:0] bad [3] = '{8'h00, 8'hFF, 8'h54};
    localparam logic [31:0] A_THR = {28'h0, `RSC_OFS_THRESH};
    localparam logic [31:0] A_CAU = {28'h0, `RSC_OFS_CAUSE};
    localparam logic [31:0] A_STS = {28'h0, `RSC_OFS_STATUS};
    localparam logic [1:0] OK = `RSC_RESP_OKAY;
    localparam logic [1:0] SLV = `RSC_RESP_SLVERR;
    int fails = 0, num_checks = 0;
    rsc_reset_source_controller dut_u (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .undervoltage_detect(undervoltage_detect),
        .slow_internal_osc(slow_internal_osc), .powerdown_mode(powerdown_mode),
        .sleep_idle_mode(sleep_idle_mode), .sys_clk_is_slow(sys_clk_is_slow),
        .watchdog_timeout(watchdog_timeout), .watchdog_reg_corrupt(watchdog_reg_corrupt),
        .sys_reset(sys_reset), .core_restart(core_restart),
        .startup_hold(startup_hold), .timeout_flag(timeout_flag),
        .powerdown_flag(powerdown_flag)
    );
    always #5 aclk = ~aclk;
    // slow oscillator from a divider, 32 core cycles a period
    always @(posedge aclk) begin
        osc_cnt <= osc_cnt + 4'h1;
        if (osc_cnt == 4'hF) slow_internal_osc <= ~slow_internal_osc;
    end
    task automatic stop_test();
        if (fails == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // response ready is raised once both valids have dropped, on the same edge that the slave raises its answer
    task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (!s_axi_awvalid && !s_axi_wvalid && !s_axi_bready) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
        check({30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [31:0] a, input logic [7:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (!s_axi_arvalid && !s_axi_rready) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, {24'h0, ed});
        check({30'h0, s_axi_rresp}, {30'h0, er});
    endtask
    // waits a bounded time for a full reset, then lets it run out
    task automatic wait_rst(input int lim, input logic exp);
        int n;
        n = 0;
        while (sys_reset !== 1'b1 && n < lim) begin
            @(negedge aclk);
            n++;
        end
        check({31'h0, sys_reset}, {31'h0, exp});
        repeat (8) @(posedge aclk);
    endtask
    task automatic pulse_wdt();
        @(posedge aclk);
        watchdog_timeout <= 1'b1;
        @(posedge aclk);
        watchdog_timeout <= 1'b0;
    endtask
    initial begin
        #100000;
        fails++;
        stop_test();
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(A_THR, 8'h55, OK);
        rd(A_CAU, 8'h00, OK);
        rd(A_STS, 8'h00, OK);
        foreach (codes[i]) begin
            wr(A_THR, codes[i], OK);
            rd(A_THR, codes[i], OK);
            wait_rst(120, 1'b0);
        end
        foreach (bad[i]) begin
            wr(A_THR, bad[i], OK);
            wait_rst(55, 1'b0);
            wait_rst(120, 1'b1);
            rd(A_THR, 8'h55, OK);
            rd(A_CAU, 8'h02, OK);
            wr(A_CAU, 8'hFD, OK);
            rd(A_CAU, 8'h00, OK);
        end
        powerdown_mode <= 1'b1;
        wr(A_THR, 8'h00, OK);
        wait_rst(120, 1'b0);
        wr(A_THR, 8'h55, OK);
        undervoltage_detect <= 1'b1;
        wait_rst(150, 1'b0);
        powerdown_mode <= 1'b0;
        undervoltage_detect <= 1'b0;
        @(posedge aclk);
        undervoltage_detect <= 1'b1;
        repeat (60) @(posedge aclk);
        undervoltage_detect <= 1'b0;
        wait_rst(40, 1'b0);
        undervoltage_detect <= 1'b1;
        wait_rst(150, 1'b1);
        undervoltage_detect <= 1'b0;
        rd(A_CAU, 8'h04, OK);
        wr(A_CAU, 8'h00, OK);
        rd(A_CAU, 8'h00, OK);
        @(posedge aclk);
        watchdog_reg_corrupt <= 1'b1;
        @(posedge aclk);
        watchdog_reg_corrupt <= 1'b0;
        wait_rst(10, 1'b1);
        rd(A_CAU, 8'h01, OK);
        wr(A_CAU, 8'h00, OK);
        pulse_wdt();
        wait_rst(10, 1'b1);
        rd(A_STS, 8'h02, OK);
        sleep_idle_mode <= 1'b1;
        for (int s = 0; s < 2; s++) begin
            sys_clk_is_slow <= s[0];
            pulse_wdt();
            @(negedge aclk);
            check({29'h0, core_restart, startup_hold, sys_reset}, 32'h6);
            repeat (20) @(posedge aclk);
            rd(A_STS, 8'h03, OK);
        end
        sleep_idle_mode <= 1'b0;
        // a full reset with both flags set must leave them alone
        @(posedge aclk);
        watchdog_reg_corrupt <= 1'b1;
        @(posedge aclk);
        watchdog_reg_corrupt <= 1'b0;
        wait_rst(10, 1'b1);
        rd(A_STS, 8'h03, OK);
        rd(A_CAU, 8'h01, OK);
        rd(32'h0000000C, 8'h00, SLV);
        rd(32'h00000100, 8'h00, SLV);
        wr(32'h00000010, 8'h00, SLV);
        wr(A_THR, 8'h33, OK);
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(A_STS, 8'h00, OK);
        rd(A_THR, 8'h55, OK);
        rd(A_CAU, 8'h00, OK);
        stop_test();
    end
endmodule
